// *** core/pcs_loader.sv ***
// Configuration loader, security cell, preload and power-up reset of the output registers
//
// Local design decisions: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module pcs_loader
  import pcs_pkg::*;
(
  input wire logic core_clk, // 20 MHz clock
  input wire logic resetn, // Synchronous reset, low active
  input wire logic hsel, // AHB select
  input wire logic [31:0] haddr, // AHB address
  input wire logic [1:0] htrans, // AHB transfer type
  input wire logic hwrite, // AHB write
  input wire logic [2:0] hsize, // AHB size
  input wire logic [31:0] hwdata, // AHB write data
  input wire logic hready, // AHB bus ready
  output logic hreadyout, // AHB slave ready
  output logic hresp, // AHB response, always OKAY
  output logic [31:0] hrdata, // AHB read data
  input wire logic [N_IN-1:0] ded_in, // Dedicated input pin levels
  input wire logic [N_IN-1:0] ded_drv, // Dedicated input pin driven
  input wire logic [N_OUT-1:0] io_in, // I/O pin levels from outside
  input wire logic [N_OUT-1:0] io_drv, // I/O pin driven from outside
  output logic [N_OUT-1:0] io_out, // I/O pin drive level
  output logic [N_OUT-1:0] io_oe, // I/O pin output enable
  output logic [N_IN-1:0] array_in, // Pin inputs to logic array
  output logic [N_OUT-1:0] array_io, // I/O pin levels to logic array
  output logic [N_OUT-1:0] array_fb, // Register feedback to logic array
  input wire logic [N_OUT-1:0] array_next // Next-state from logic array
);

  // Bus address phase capture
  logic dp_valid_q, dp_valid_d;
  logic dp_write_q, dp_write_d;
  logic [7:0] dp_addr_q, dp_addr_d;
  logic rd_wait_q, rd_wait_d;
  // Loader state
  pcs_state_t state_q, state_d;
  logic [7:0] wcnt_q, wcnt_d;
  logic with_sig_q, with_sig_d;
  logic secure_q, secure_d;
  logic refused_q, refused_d;
  logic [31:0] sig_lo_q, sig_lo_d;
  logic [31:0] sig_hi_q, sig_hi_d;
  logic [7:0] raddr_q, raddr_d;
  logic [2*N_OUT-1:0] outcfg_q, outcfg_d;
  // Output registers and pin synchronisers
  logic [N_OUT-1:0] oreg_q, oreg_d;
  logic [N_IN-1:0] ded_s1_q, ded_s2_q, ded_drv_s1_q, ded_drv_s2_q;
  logic [N_OUT-1:0] io_s1_q, io_s2_q, io_drv_s1_q, io_drv_s2_q;
  // Memory port
  logic mem_we;
  logic [7:0] mem_wa;
  logic [31:0] mem_wd;
  logic [31:0] mem_rd;
  // Data phase decode
  logic wr_go, rd_go, data_stall;

  // Pull-up: a pin nobody drives reads as one
  function automatic logic [N_OUT-1:0] pull_up(input logic [N_OUT-1:0] lvl,
                                               input logic [N_OUT-1:0] drv);
    pull_up = (lvl & drv) | ~drv;
  endfunction : pull_up

  // Dedicated inputs are wider than the I/O group
  function automatic logic [N_IN-1:0] pull_up_in(input logic [N_IN-1:0] lvl,
                                                 input logic [N_IN-1:0] drv);
    pull_up_in = (lvl & drv) | ~drv;
  endfunction : pull_up_in

  function automatic logic is_wr(input logic [7:0] ofs, input logic [7:0] a);
    is_wr = (a == ofs);
  endfunction : is_wr

  pcs_fuse_mem u_mem (
    .core_clk(core_clk),
    .wr_en(mem_we),
    .wr_addr(mem_wa),
    .wr_data(mem_wd),
    .rd_addr(raddr_q),
    .rd_data(mem_rd)
  );

  // Stall data writes while erasing, and give RDATA reads one wait state
  always_comb begin
    data_stall = 1'b0;
    if (dp_valid_q && dp_write_q && is_wr(OFS_DATA, dp_addr_q) && state_q == PCS_ERASE) begin
      data_stall = 1'b1;
    end
    if (dp_valid_q && !dp_write_q && is_wr(OFS_RDATA, dp_addr_q) && !rd_wait_q) begin
      data_stall = 1'b1;
    end
    hreadyout = ~data_stall;
    hresp = 1'b0;
    wr_go = dp_valid_q && dp_write_q && !data_stall;
    rd_go = dp_valid_q && !dp_write_q && !data_stall;
  end

  // Address phase pipeline
  always_comb begin
    dp_valid_d = dp_valid_q;
    dp_write_d = dp_write_q;
    dp_addr_d = dp_addr_q;
    rd_wait_d = 1'b0;
    if (data_stall) begin
      rd_wait_d = !dp_write_q;
    end else if (hready) begin
      dp_valid_d = hsel && htrans[1];
      dp_write_d = hwrite;
      dp_addr_d = haddr[7:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      dp_valid_q <= 1'b0;
      dp_write_q <= 1'b0;
      dp_addr_q <= RST_IDX;
      rd_wait_q <= 1'b0;
    end else begin
      dp_valid_q <= dp_valid_d;
      dp_write_q <= dp_write_d;
      dp_addr_q <= dp_addr_d;
      rd_wait_q <= rd_wait_d;
    end
  end

  // Loader sequencing, security cell and signature store
  always_comb begin
    state_d = state_q;
    wcnt_d = wcnt_q;
    with_sig_d = with_sig_q;
    secure_d = secure_q;
    refused_d = refused_q;
    sig_lo_d = sig_lo_q;
    sig_hi_d = sig_hi_q;
    raddr_d = raddr_q;
    outcfg_d = outcfg_q;
    mem_we = 1'b0;
    mem_wa = wcnt_q;
    mem_wd = hwdata;
    case (state_q)
      PCS_ERASE: begin
        // Erase walks every array word to zero before any load is accepted
        mem_we = 1'b1;
        mem_wd = RST_WORD;
        if (wcnt_q == LAST_ARRAY_WORD) begin
          wcnt_d = RST_IDX;
          state_d = PCS_LOAD;
        end else begin
          wcnt_d = wcnt_q + 8'h01;
        end
      end
      PCS_LOAD: begin
        if (wr_go && is_wr(OFS_DATA, dp_addr_q)) begin
          if (wcnt_q < ARRAY_WORDS) begin
            mem_we = 1'b1;
            // Unused high bits of the last array word are kept at zero
            mem_wd = (wcnt_q == LAST_ARRAY_WORD) ? (hwdata & LAST_MASK) : hwdata;
          end else if (wcnt_q == SIG_WORD_LO) begin
            sig_lo_d = hwdata;
          end else begin
            sig_hi_d = hwdata;
          end
          wcnt_d = wcnt_q + 8'h01;
          if (wcnt_q == (with_sig_q ? SIG_WORD_HI : LAST_ARRAY_WORD)) begin
            state_d = PCS_DONE;
          end
        end
      end
      PCS_IDLE, PCS_DONE: begin
      end
      default: state_d = PCS_IDLE;
    endcase
    if (wr_go && is_wr(OFS_CTRL, dp_addr_q)) begin
      if (hwdata[CTRL_START]) begin
        // Apart from reset, a new cycle is the only path that clears the security cell
        state_d = PCS_ERASE;
        wcnt_d = RST_IDX;
        with_sig_d = hwdata[CTRL_WITH_SIG];
        secure_d = 1'b0;
        sig_lo_d = RST_WORD;
        sig_hi_d = RST_WORD;
        outcfg_d = '0;
      end else if (hwdata[CTRL_SEC_SET]) begin
        secure_d = 1'b1;
      end
    end
    if (wr_go && is_wr(OFS_RADDR, dp_addr_q)) begin
      raddr_d = hwdata[7:0];
    end
    if (wr_go && is_wr(OFS_OUTCFG, dp_addr_q)) begin
      outcfg_d = hwdata[2*N_OUT-1:0];
    end
    if (rd_go && is_wr(OFS_RDATA, dp_addr_q)) begin
      refused_d = secure_q && (raddr_q < ARRAY_WORDS);
    end
  end

  // Reset clears every register in one edge, well inside TPR_CYC
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      state_q <= PCS_IDLE;
      wcnt_q <= RST_IDX;
      with_sig_q <= 1'b0;
      secure_q <= 1'b0;
      refused_q <= 1'b0;
      sig_lo_q <= RST_WORD;
      sig_hi_q <= RST_WORD;
      raddr_q <= RST_IDX;
      outcfg_q <= '0;
    end else begin
      state_q <= state_d;
      wcnt_q <= wcnt_d;
      with_sig_q <= with_sig_d;
      secure_q <= secure_d;
      refused_q <= refused_d;
      sig_lo_q <= sig_lo_d;
      sig_hi_q <= sig_hi_d;
      raddr_q <= raddr_d;
      outcfg_q <= outcfg_d;
    end
  end

  // Output registers: preload wins over the array, feedback path ignored that edge
  always_comb begin
    oreg_d = array_next;
    if (wr_go && is_wr(OFS_PRELOAD, dp_addr_q)) begin
      oreg_d = hwdata[N_OUT-1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      oreg_q <= '0;
    end else begin
      oreg_q <= oreg_d;
    end
  end

  // Pin synchronisers on raw level and driven flag; pull-up applied after the second stage
  // Cleared to zero, an undriven flag still makes the pin read as one
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ded_s1_q <= '0;
      ded_s2_q <= '0;
      ded_drv_s1_q <= '0;
      ded_drv_s2_q <= '0;
      io_s1_q <= '0;
      io_s2_q <= '0;
      io_drv_s1_q <= '0;
      io_drv_s2_q <= '0;
    end else begin
      ded_s1_q <= ded_in;
      ded_s2_q <= ded_s1_q;
      ded_drv_s1_q <= ded_drv;
      ded_drv_s2_q <= ded_drv_s1_q;
      io_s1_q <= io_in;
      io_s2_q <= io_s1_q;
      io_drv_s1_q <= io_drv;
      io_drv_s2_q <= io_drv_s1_q;
    end
  end

  // Pin drive and array connections
  always_comb begin
    io_out = oreg_q ^ outcfg_q[N_OUT-1:0];
    io_oe = outcfg_q[CFG_EN +: N_OUT];
    array_in = pull_up_in(ded_s2_q, ded_drv_s2_q);
    // Own drive wins on an enabled pin; it is on this clock, so no synchroniser
    array_io = (io_out & io_oe) | (pull_up(io_s2_q, io_drv_s2_q) & ~io_oe);
    array_fb = oreg_q;
  end

  // Read data mux; array words masked while secured, signature always open
  always_comb begin
    hrdata = RST_WORD;
    if (dp_valid_q && !dp_write_q) begin
      case (dp_addr_q)
        OFS_CTRL: hrdata = 32'(with_sig_q) << CTRL_WITH_SIG;
        OFS_STATUS: hrdata = (32'(state_q) << ST_STATE) | (32'(secure_q) << ST_SECURE) |
                             (32'(refused_q) << ST_REFUSED) | (32'(wcnt_q) << ST_COUNT);
        OFS_RADDR: hrdata = 32'(raddr_q);
        OFS_RDATA: begin
          if (raddr_q < ARRAY_WORDS) begin
            hrdata = secure_q ? RST_WORD : mem_rd;
          end else if (raddr_q == SIG_WORD_LO) begin
            hrdata = sig_lo_q;
          end else if (raddr_q == SIG_WORD_HI) begin
            hrdata = sig_hi_q;
          end
        end
        OFS_SIG_LO: hrdata = sig_lo_q;
        OFS_SIG_HI: hrdata = sig_hi_q;
        OFS_OUTCFG: hrdata = 32'(outcfg_q);
        OFS_OUTSTATE: hrdata = 32'(oreg_q);
        default: hrdata = RST_WORD;
      endcase
    end
  end

endmodule : pcs_loader

// *** core/pcs_pkg.sv ***
// Constants, register map and types for the configuration and security loader
package pcs_pkg;

  // Image geometry
  localparam int ARRAY_BITS = 5828;
  localparam int SIG_BITS = 64;
  localparam int IMAGE_BITS = ARRAY_BITS + SIG_BITS;
  localparam int WORD_BITS = 32;
  localparam int ARRAY_WORDS_I = (ARRAY_BITS + WORD_BITS - 1) / WORD_BITS;
  localparam int SIG_WORDS_I = SIG_BITS / WORD_BITS;
  localparam logic [7:0] ARRAY_WORDS = 8'(ARRAY_WORDS_I);
  localparam logic [7:0] LAST_ARRAY_WORD = 8'(ARRAY_WORDS_I - 1);
  localparam logic [7:0] SIG_WORD_LO = 8'(ARRAY_WORDS_I);
  localparam logic [7:0] SIG_WORD_HI = 8'(ARRAY_WORDS_I + SIG_WORDS_I - 1);
  localparam int LAST_BITS = ARRAY_BITS - (ARRAY_WORDS_I - 1) * WORD_BITS;
  localparam logic [31:0] LAST_MASK = 32'((64'h1 << LAST_BITS) - 64'h1);

  // Pins
  localparam int N_OUT = 10;
  localparam int N_IN = 12;

  // Power-up reset time and its cycle budget at 50 ns
  localparam int TPR_NS = 1000;
  localparam int CLK_NS = 50;
  localparam int TPR_CYC = (TPR_NS / CLK_NS) < 1 ? 1 : (TPR_NS / CLK_NS);

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_DATA = 8'h08;
  localparam logic [7:0] OFS_RADDR = 8'h0C;
  localparam logic [7:0] OFS_RDATA = 8'h10;
  localparam logic [7:0] OFS_SIG_LO = 8'h14;
  localparam logic [7:0] OFS_SIG_HI = 8'h18;
  localparam logic [7:0] OFS_OUTCFG = 8'h1C;
  localparam logic [7:0] OFS_PRELOAD = 8'h20;
  localparam logic [7:0] OFS_OUTSTATE = 8'h24;

  // Field positions
  localparam int CTRL_START = 0;
  localparam int CTRL_WITH_SIG = 1;
  localparam int CTRL_SEC_SET = 2;
  localparam int ST_STATE = 0;
  localparam int ST_SECURE = 2;
  localparam int ST_REFUSED = 3;
  localparam int ST_COUNT = 8;
  localparam int CFG_EN = 10;

  // Reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [7:0] RST_IDX = 8'h00;

  typedef enum logic [1:0] {
    PCS_IDLE,
    PCS_ERASE,
    PCS_LOAD,
    PCS_DONE
  } pcs_state_t;

endpackage : pcs_pkg

// *** core/pcs_fuse_mem.sv ***
// Fuse word store: one write port, registered read port
`timescale 1ns/1ps
module pcs_fuse_mem
  import pcs_pkg::*;
(
  input wire logic core_clk, // Clock
  input wire logic wr_en, // Write strobe
  input wire logic [7:0] wr_addr, // Write word index
  input wire logic [31:0] wr_data, // Write word
  input wire logic [7:0] rd_addr, // Read word index
  output logic [31:0] rd_data // Registered read word
);

  logic [31:0] mem_q [0:ARRAY_WORDS_I-1];

  // No reset on the array; erase is done by the loader walking it
  always_ff @(posedge core_clk) begin
    if (wr_en && (wr_addr < ARRAY_WORDS)) begin
      mem_q[wr_addr] <= wr_data;
    end
    if (rd_addr < ARRAY_WORDS) begin
      rd_data <= mem_q[rd_addr];
    end else begin
      rd_data <= RST_WORD;
    end
  end

endmodule : pcs_fuse_mem

// *** tb/pcs_loader_properties.sv ***
// Port-level checker for the loader, bound to its top module
`timescale 1ns/1ps
module pcs_loader_properties
  import pcs_pkg::*;
(
  input wire logic core_clk, // Clock
  input wire logic resetn, // Reset, low active
  input wire logic hsel, // Select
  input wire logic [31:0] haddr, // Address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  input wire logic hreadyout, // Slave ready
  input wire logic [31:0] hrdata, // Read data
  input wire logic [N_IN-1:0] ded_in, // Pin levels
  input wire logic [N_IN-1:0] ded_drv, // Pin driven
  input wire logic [N_OUT-1:0] io_out, // Pin drive
  input wire logic [N_OUT-1:0] io_oe, // Pin enable
  input wire logic [N_IN-1:0] array_in, // Array inputs
  input wire logic [N_OUT-1:0] array_fb, // Feedback
  input wire logic [N_OUT-1:0] array_next // Next state
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  logic ph_q, w_q, sec_q;
  logic [7:0] a_q, ra_q;
  wire done_w = ph_q && hreadyout && w_q;
  wire rd_w = ph_q && hreadyout && !w_q;
  wire pl_w = done_w && a_q == OFS_PRELOAD;
  wire [N_IN-1:0] pin_w = ded_in | ~ded_drv;
  wire [N_OUT-1:0] pl_v = hwdata[N_OUT-1:0];
  // Own copy of the data phase, security cell and readback index
  always_ff @(posedge core_clk) begin
    if (hready) begin
      ph_q <= resetn && hsel && htrans[1];
      a_q <= haddr[7:0];
      w_q <= hwrite;
    end
    if (!resetn) begin
      sec_q <= 1'b0;
      ra_q <= RST_IDX;
    end else if (done_w && a_q == OFS_CTRL) begin
      sec_q <= !hwdata[CTRL_START] && (sec_q || hwdata[CTRL_SEC_SET]);
    end else if (done_w && a_q == OFS_RADDR) begin
      ra_q <= hwdata[7:0];
    end
  end
  a_reset_clears_fb: assert property ($rose(resetn) |-> array_fb == '0)
    else $error("feedback not cleared by reset");
  a_reset_pins_low: assert property ($rose(resetn) |-> io_out == '0 && io_oe == '0)
    else $error("pins not low after reset");
  a_pullup_undriven: assert property ($past(resetn) && $past(resetn, 2) |-> array_in == $past(pin_w, 2))
    else $error("undriven pin not read high");
  a_preload_forces: assert property (pl_w |=> array_fb == $past(pl_v))
    else $error("preload value not loaded");
  a_preload_then_next: assert property (pl_w ##1 !pl_w |=> array_fb == $past(array_next))
    else $error("no next state after preload");
  a_normal_load: assert property (resetn && !pl_w |=> array_fb == $past(array_next))
    else $error("register missed next state");
  a_secure_read_zero: assert property (rd_w && a_q == OFS_RDATA && sec_q && ra_q < SIG_WORD_LO |-> hrdata == '0)
    else $error("secured array word readable");
  a_secure_flag_held: assert property (rd_w && a_q == OFS_STATUS |-> hrdata[ST_SECURE] == sec_q)
    else $error("secure flag wrong");
  c_preload: cover property (pl_w);
  c_secure_read: cover property (rd_w && a_q == OFS_RDATA && sec_q);
  c_status_read: cover property (rd_w && a_q == OFS_STATUS);
endmodule : pcs_loader_properties

bind pcs_loader pcs_loader_properties chk_u (.core_clk, .resetn, .hsel, .haddr, .htrans, .hwrite,
  .hwdata, .hready, .hreadyout, .hrdata, .ded_in, .ded_drv, .io_out, .io_oe, .array_in,
  .array_fb, .array_next);

// *** tb/pcs_array_model.sv ***
// Logic array stand-in: a counter fed from the register feedback
`timescale 1ns/1ps
module pcs_array_model
  import pcs_pkg::*;
(
  array_fb, // Register feedback
  array_next // Next state
);
  input wire logic [N_OUT-1:0] array_fb;
  output logic [N_OUT-1:0] array_next;
  // Counting makes a stale or skipped load visible at once
  assign array_next = array_fb + 10'h001;
endmodule : pcs_array_model

// *** tb/tb_pcs_loader.sv ***
// Self-checking bench: reset, pins, programming, security, preload
`timescale 1ns/1ps
module tb_pcs_loader
  import pcs_pkg::*;
;
  logic core_clk, resetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd_v;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [N_IN-1:0] ded_in, ded_drv, array_in;
  logic [N_OUT-1:0] io_in, io_drv, io_out, io_oe, array_io, array_fb, array_next;
  logic [7:0] idx [5] = '{8'h00, 8'h64, 8'hB6, 8'hB7, 8'hB8};
  int n_mismatch = 0;
  int checks_done = 0;
  assign hready = hreadyout;
  pcs_loader dut_u (.core_clk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout, .hresp, .hrdata, .ded_in, .ded_drv, .io_in, .io_drv, .io_out,
    .io_oe, .array_in, .array_io, .array_fb, .array_next);
  pcs_array_model far_u (.array_fb, .array_next);
  // 50 ns clock
  initial begin
    core_clk = 1'b0;
    #100;
    forever #25 core_clk = ~core_clk;
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  // Single transfer; waits on hready in address and data phase, so wait states are allowed
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h000000, a};
    hwrite <= w;
    do @(posedge core_clk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge core_clk); while (hready !== 1'b1);
    rd_v = hrdata;
  endtask : xfer
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rd_v, exp);
    chk({31'h0, hresp}, 32'h0);
  endtask : rd
  function automatic logic [31:0] word(input logic [7:0] k, input logic [7:0] s);
    return (k == LAST_ARRAY_WORD) ? {s, 16'hC3A5, k} & LAST_MASK : {s, 16'hC3A5, k};
  endfunction : word
  task automatic peek(input logic [7:0] k, input logic [31:0] exp);
    xfer(1'b1, OFS_RADDR, {24'h0, k});
    rd(OFS_RDATA, exp);
  endtask : peek
  // No separate erase step: start, then stream the words
  task automatic prog(input logic sig, input logic [7:0] s);
    xfer(1'b1, OFS_CTRL, {30'h0, sig, 1'b1});
    xfer(1'b0, OFS_STATUS, 32'h0);
    chk(rd_v & 32'h3, 32'h1);
    for (int k = 0; k < ARRAY_WORDS_I + (sig ? SIG_WORDS_I : 0); k++) begin
      xfer(1'b1, OFS_DATA, {s, 16'hC3A5, 8'(k)});
    end
    xfer(1'b0, OFS_STATUS, 32'h0);
    chk(rd_v & 32'h3, 32'h3);
  endtask : prog
  initial begin
    #2_000_000;
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    resetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    ded_in = 12'hA53;
    ded_drv = 12'h000;
    io_in = 10'h2B4;
    io_drv = 10'h000;
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    @(negedge core_clk);
    chk({22'h0, array_fb}, 32'h0);
    chk({22'h0, io_out}, 32'h0);
    chk({22'h0, io_oe}, 32'h0);
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    chk({20'h0, array_in}, 32'h00000FFF);
    chk({22'h0, array_io}, 32'h000003FF);
    @(posedge core_clk);
    ded_drv <= 12'hFFF;
    io_drv <= 10'h3FF;
    repeat (4) @(negedge core_clk);
    chk({20'h0, array_in}, 32'h00000A53);
    chk({22'h0, array_io}, 32'h000002B4);
    rd(OFS_OUTCFG, RST_WORD);
    rd(OFS_STATUS, RST_WORD);
    xfer(1'b1, 8'h30, 32'hFFFFFFFF);
    rd(8'h30, 32'h0);
    $display("test reset and pins done");
    prog(1'b1, 8'h11);
    rd(OFS_CTRL, 32'h00000002);
    foreach (idx[i]) peek(idx[i], word(idx[i], 8'h11));
    rd(OFS_SIG_LO, word(SIG_WORD_LO, 8'h11));
    rd(OFS_SIG_HI, word(SIG_WORD_HI, 8'h11));
    $display("test full image done");
    xfer(1'b1, OFS_CTRL, 32'h4);
    peek(8'h05, 32'h0);
    xfer(1'b0, OFS_STATUS, 32'h0);
    chk(rd_v & 32'hC, 32'hC);
    peek(SIG_WORD_HI, word(SIG_WORD_HI, 8'h11));
    rd(OFS_SIG_LO, word(SIG_WORD_LO, 8'h11));
    $display("test security done");
    prog(1'b0, 8'h22);
    xfer(1'b0, OFS_STATUS, 32'h0);
    chk(rd_v & 32'h4, 32'h0);
    for (int i = 0; i < 3; i++) peek(idx[i], word(idx[i], 8'h22));
    rd(OFS_SIG_LO, 32'h0);
    $display("test short image done");
    xfer(1'b1, OFS_OUTCFG, 32'h000FFCF0);
    rd(OFS_OUTCFG, 32'h000FFCF0);
    chk({22'h0, io_oe}, 32'h000003FF);
    foreach (idx[i]) begin
      xfer(1'b1, OFS_PRELOAD, {22'h0, idx[i], 2'b01});
      @(negedge core_clk);
      chk({22'h0, array_fb}, {22'h0, idx[i], 2'b01});
      chk({22'h0, io_out}, {22'h0, idx[i], 2'b01} ^ 32'h0F0);
      @(negedge core_clk);
      chk({22'h0, array_fb}, {22'h0, idx[i], 2'b10});
      repeat (4) @(negedge core_clk);
      chk({22'h0, array_fb}, {22'h0, idx[i], 2'b10} + 32'h4);
    end
    // Two edges pass between the preload and the read data phase
    xfer(1'b1, OFS_PRELOAD, 32'h00000155);
    rd(OFS_OUTSTATE, 32'h00000157);
    $display("test preload done");
    report_and_stop();
  end
endmodule : tb_pcs_loader
